// File: core/ssp_pkg.sv
// constants, field positions and carrier structs for the serial port register bank
// assumes a 32-bit AXI4-Lite master and a serial engine on the same clock
package ssp_pkg;
  // byte addresses of the word registers
  localparam logic [3:0] ADDR_STATUS  = 4'h0;
  localparam logic [3:0] ADDR_CONTROL = 4'h4;
  localparam logic [3:0] ADDR_BUFFER  = 4'h8;
  localparam logic [3:0] ADDR_RELOAD  = 4'hC;
  localparam logic [7:0] STATUS_RESET  = 8'h00;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] RELOAD_RESET  = 8'h00;
  // status fields
  localparam int ST_SAMPLE = 7;
  localparam int ST_EDGE   = 6;
  // control fields
  localparam int CT_WRITE_COLLISION = 7;
  localparam int CT_OVF  = 6;
  localparam int CT_EN   = 5;
  localparam int CT_CKP  = 4;
  // port_mode encodings
  localparam logic [3:0] M_SPI_D4   = 4'h0;
  localparam logic [3:0] M_SPI_D16  = 4'h1;
  localparam logic [3:0] M_SPI_D64  = 4'h2;
  localparam logic [3:0] M_SPI_T2   = 4'h3;
  localparam logic [3:0] M_SPI_SS   = 4'h4;
  localparam logic [3:0] M_SPI_NOSS = 4'h5;
  localparam logic [3:0] M_I2C_S7   = 4'h6;
  localparam logic [3:0] M_I2C_S10  = 4'h7;
  localparam logic [3:0] M_I2C_MBRG = 4'h8;
  localparam logic [3:0] M_SPI_BRG  = 4'hA;
  localparam logic [3:0] M_I2C_MFW  = 4'hB;
  localparam logic [3:0] M_I2C_S7SP = 4'hE;
  localparam logic [3:0] M_I2C_S10SP= 4'hF;
  // divide ratios, in system clocks per serial clock period
  localparam logic [9:0] DIV_4  = 10'h004;
  localparam logic [9:0] DIV_16 = 10'h010;
  localparam logic [9:0] DIV_64 = 10'h040;
  localparam logic [7:0] SPI_RELOAD_MIN = 8'h01;
  localparam logic [7:0] I2C_RELOAD_MIN = 8'h03;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic        awvalid;
    logic [3:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [3:0]  araddr;
    logic        rready;
  } axi_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axi_rsp_s;

  // events from the shift engine, one-cycle pulses unless noted
  typedef struct packed {
    logic       byte_done;    // a byte finished shifting in
    logic [7:0] rx_byte;
    logic       byte_is_data; // level with byte_done
    logic       start_det;
    logic       stop_det;
    logic       nack_det;
    logic       addr_match;
    logic       addr_rw;      // level with addr_match
    logic       tx_shifting;  // level: data bits leaving the shift register
    logic       tx_done;      // data bits of a transmit ended
    logic       ua_req;       // 10-bit slave wants a new address
    logic       t2_match;
    logic [4:0] seq_req;      // start, restart, stop, receive, ack requests (level)
  } engine_ev_s;

  typedef struct packed {
    logic       pins_to_port;
    logic       spi_master;
    logic       spi_slave;
    logic       ss_used;
    logic       i2c_master;
    logic       i2c_slave;
    logic       fw_master;
    logic       ten_bit;
    logic       start_stop_irq;
    logic       sample_at_end;
    logic       slew_limit;
    logic       smbus_levels;
    logic       shift_act_to_idle;
    logic       clk_idle_high;
    logic       scl_hold_low;
    logic       mode_bad;
    logic       sck_tick;     // one pulse per serial clock period
    logic       tx_load;      // pulse: buffer written, start shifting
    logic [7:0] tx_byte;
  } port_ctrl_s;
endpackage

// File: core/ssp_regs.sv
// status and first control register of the serial port, on an AXI4-Lite slave
// assumes the shift engine sits on clk_sys and reports events as pulses
//
// What this block does
// - master sample phase: end or middle; slave zero
// - i2c: sample_phase one disables slew limiting
// - spi: clock_edge_select picks shift-out transition
// - i2c: clock_edge_select selects smbus input thresholds
// - data_not_address follows last i2c byte kind
// - stop_seen marks stop last, cleared when disabled
// - start_seen marks start last, cleared when disabled
// - slave direction_info holds last matched rw bit, cleared on start, stop or nack
// - master direction_info shows transmit in progress
// - 10-bit slave flags needed address reload
// - buffer_full on receive, and during i2c transmit
// - write_collision on illegal buffer write, software clears
// - spi slave overflow discards byte, never in master
// - i2c receive overflow set, cleared only by software
// - port_enable hands pins to the port
// - clock_polarity sets spi idle clock level
// - i2c slave clock_polarity zero stretches clock
// - modes 0..2: spi master divide 4/16/64
// - mode 3 timer half rate, mode A reload
// - modes 4/5 spi slave with or without select
// - i2c slave 7/10-bit, start/stop interrupt variants
// - i2c master reload clock, firmware master, reserved
//
// The implementer's own choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
module ssp_regs (
  input  wire logic                 clk_sys,
  input  wire logic                 arst_n,
  input  wire ssp_pkg::axi_req_s    axi_req,
  output ssp_pkg::axi_rsp_s         axi_rsp,
  input  wire ssp_pkg::engine_ev_s  eng,
  output ssp_pkg::port_ctrl_s       ctrl
);
  import ssp_pkg::*;
  // every check below runs on clk_sys and sleeps through reset
  default clocking cb_sys @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  ////////////////////////////////////////////////////////////////////////////
  // register state
  logic [1:0] stat_sw_q;                  // sample_phase, clock_edge_select
  logic       dna_q, stop_q, start_q, rw_q, ua_q, bf_q;
  logic       write_collision_q, ovf_q;
  logic [5:0] ctl_q;                      // port_enable, clock_polarity, port_mode
  logic [7:0] rxbuf_q, reload_q, txbyte_q;
  logic       txload_q;
  logic [9:0] div_cnt_q;
  logic       t2_half_q, tick_q;
  logic       aw_got_q, w_got_q, bvalid_q, rvalid_q;
  logic [3:0] awaddr_q;
  logic [7:0] wbyte_q;
  logic       wlane_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // mode decoding
  wire [3:0] mode   = ctl_q[3:0];
  wire       enable = ctl_q[CT_EN];
  wire       clock_polarity    = ctl_q[CT_CKP];
  wire spi_m  = (mode == M_SPI_D4) || (mode == M_SPI_D16) || (mode == M_SPI_D64) ||
                (mode == M_SPI_T2) || (mode == M_SPI_BRG);
  wire spi_s  = (mode == M_SPI_SS) || (mode == M_SPI_NOSS);
  wire i2c_s  = (mode == M_I2C_S7) || (mode == M_I2C_S10) ||
                (mode == M_I2C_S7SP) || (mode == M_I2C_S10SP);
  wire i2c_m  = (mode == M_I2C_MBRG) || (mode == M_I2C_MFW);
  wire is_i2c = i2c_s || i2c_m;
  wire ten    = (mode == M_I2C_S10) || (mode == M_I2C_S10SP);
  // reserved codes and unsupported reload values are flagged, not fixed up
  wire bad    = !(spi_m || spi_s || is_i2c) ||
                ((mode == M_SPI_BRG) && (reload_q < SPI_RELOAD_MIN)) ||
                ((mode == M_I2C_MBRG) && (reload_q < I2C_RELOAD_MIN));

  ////////////////////////////////////////////////////////////////////////////
  // bus handshakes and address decode
  wire aw_hs   = axi_req.awvalid && !aw_got_q && !bvalid_q;
  wire w_hs    = axi_req.wvalid && !w_got_q && !bvalid_q;
  wire wr_fire = aw_got_q && w_got_q && !bvalid_q;
  wire ar_hs   = axi_req.arvalid && !rvalid_q;
  wire wr_st   = wr_fire && wlane_q && (awaddr_q == ADDR_STATUS);
  wire wr_ct   = wr_fire && wlane_q && (awaddr_q == ADDR_CONTROL);
  wire wr_bf   = wr_fire && wlane_q && (awaddr_q == ADDR_BUFFER);
  wire wr_rl   = wr_fire && wlane_q && (awaddr_q == ADDR_RELOAD);
  wire rd_bf   = ar_hs && (axi_req.araddr == ADDR_BUFFER);
  wire wr_map  = (awaddr_q == ADDR_STATUS) || (awaddr_q == ADDR_CONTROL) ||
                 (awaddr_q == ADDR_BUFFER) || (awaddr_q == ADDR_RELOAD);

  // read data mux; unmapped words read zero with an error response
  logic [7:0] rd_byte;
  logic       rd_ok;
  always_comb begin
    rd_ok = 1'b1;
    if (axi_req.araddr == ADDR_STATUS) begin
      rd_byte = {stat_sw_q, dna_q, stop_q, start_q, rw_q, ua_q, bf_q};
    end else if (axi_req.araddr == ADDR_CONTROL) begin
      rd_byte = {write_collision_q, ovf_q, ctl_q};
    end else if (axi_req.araddr == ADDR_BUFFER) begin
      rd_byte = rxbuf_q;
    end else if (axi_req.araddr == ADDR_RELOAD) begin
      rd_byte = reload_q;
    end else begin
      rd_byte = 8'h00;
      rd_ok   = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial event qualification
  wire rx_land   = eng.byte_done && !bf_q && (spi_m || spi_s || is_i2c);
  wire ovf_set   = eng.byte_done && bf_q && (spi_s || is_i2c);
  // i2c master can only load the buffer when the bus is idle
  wire m_busy    = |eng.seq_req || eng.tx_shifting;
  wire write_collision_set  = wr_bf && ((i2c_m && m_busy) ||
                   ((i2c_s || spi_s) && eng.tx_shifting));
  wire tx_accept = wr_bf && !write_collision_set && enable;
  wire i2c_tx    = is_i2c && tx_accept;

  ////////////////////////////////////////////////////////////////////////////
  // status flags held by hardware
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      stat_sw_q <= STATUS_RESET[ST_SAMPLE:ST_EDGE];
      dna_q     <= 1'b0;
      stop_q    <= 1'b0;
      start_q   <= 1'b0;
      rw_q      <= 1'b0;
      ua_q      <= 1'b0;
      bf_q      <= 1'b0;
    end else begin
      if (wr_st) begin
        stat_sw_q <= wbyte_q[ST_SAMPLE:ST_EDGE];
      end
      if (is_i2c && eng.byte_done) begin
        dna_q <= eng.byte_is_data;
      end
      if (!enable) begin
        stop_q  <= 1'b0;
        start_q <= 1'b0;
      end else if (is_i2c && eng.stop_det) begin
        stop_q  <= 1'b1;
        start_q <= 1'b0;
      end else if (is_i2c && eng.start_det) begin
        start_q <= 1'b1;
        stop_q  <= 1'b0;
      end
      if (i2c_m) begin
        rw_q <= eng.tx_shifting;
      end else if (i2c_s && eng.addr_match) begin
        rw_q <= eng.addr_rw;
      end else if (i2c_s && (eng.start_det || eng.stop_det || eng.nack_det)) begin
        rw_q <= 1'b0;
      end
      // a new request outranks the reload write that clears it
      if (ten && eng.ua_req) begin
        ua_q <= 1'b1;
      end else if (wr_rl || !ten) begin
        ua_q <= 1'b0;
      end
      if (rx_land || i2c_tx) begin
        bf_q <= 1'b1;
      end else if (rd_bf || (is_i2c && eng.tx_done)) begin
        bf_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register, sticky errors and data buffers
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ctl_q    <= CONTROL_RESET[5:0];
      write_collision_q   <= CONTROL_RESET[CT_WRITE_COLLISION];
      ovf_q    <= CONTROL_RESET[CT_OVF];
      reload_q <= RELOAD_RESET;
      rxbuf_q  <= 8'h00;
      txbyte_q <= 8'h00;
      txload_q <= 1'b0;
    end else begin
      if (wr_ct) begin
        ctl_q <= wbyte_q[5:0];
      end
      // set wins over a software clear in the same cycle
      if (write_collision_set) begin
        write_collision_q <= 1'b1;
      end else if (wr_ct && !wbyte_q[CT_WRITE_COLLISION]) begin
        write_collision_q <= 1'b0;
      end
      if (ovf_set) begin
        ovf_q <= 1'b1;
      end else if (wr_ct && !wbyte_q[CT_OVF]) begin
        ovf_q <= 1'b0;
      end
      if (wr_rl) begin
        reload_q <= wbyte_q;
      end
      // an overflowed byte is dropped, the old one is kept
      if (rx_land) begin
        rxbuf_q <= eng.rx_byte;
      end
      if (tx_accept) begin
        txbyte_q <= wbyte_q;
      end
      txload_q <= tx_accept;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial clock rate: one tick per serial clock period
  logic [9:0] div_ratio;
  always_comb begin
    if (mode == M_SPI_D4) begin
      div_ratio = DIV_4;
    end else if (mode == M_SPI_D16) begin
      div_ratio = DIV_16;
    end else if (mode == M_SPI_D64) begin
      div_ratio = DIV_64;
    end else begin
      div_ratio = {reload_q + 8'h01, 2'b00};
    end
  end
  wire div_wrap = (div_cnt_q >= div_ratio - 10'h001);
  wire t2_rate  = (mode == M_SPI_T2);
  wire use_div  = enable && !bad && !t2_rate && (spi_m || (mode == M_I2C_MBRG));

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      div_cnt_q <= 10'h000;
      t2_half_q <= 1'b0;
      tick_q    <= 1'b0;
    end else begin
      div_cnt_q <= (!use_div || div_wrap) ? 10'h000 : div_cnt_q + 10'h001;
      // timer-2 rate: every second match is one serial period
      if (enable && t2_rate && eng.t2_match) begin
        t2_half_q <= !t2_half_q;
      end
      tick_q <= (use_div && div_wrap) ||
                (enable && t2_rate && eng.t2_match && t2_half_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus slave
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      aw_got_q <= 1'b0;
      w_got_q  <= 1'b0;
      awaddr_q <= 4'h0;
      wbyte_q  <= 8'h00;
      wlane_q  <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= RESP_OKAY;
    end else begin
      if (aw_hs) begin
        aw_got_q <= 1'b1;
        awaddr_q <= axi_req.awaddr;
      end else if (wr_fire) begin
        aw_got_q <= 1'b0;
      end
      if (w_hs) begin
        w_got_q <= 1'b1;
        wbyte_q <= axi_req.wdata[7:0];
        wlane_q <= axi_req.wstrb[0];
      end else if (wr_fire) begin
        w_got_q <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_map ? RESP_OKAY : RESP_SLVERR;
      end else if (axi_req.bready) begin
        bvalid_q <= 1'b0;
      end
      if (ar_hs) begin
        rvalid_q <= 1'b1;
        rdata_q  <= {24'h00_0000, rd_byte};
        rresp_q  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (axi_req.rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // handshake outputs combinational, data from flops
  assign axi_rsp.awready = !aw_got_q && !bvalid_q;
  assign axi_rsp.wready  = !w_got_q && !bvalid_q;
  assign axi_rsp.bvalid  = bvalid_q;
  assign axi_rsp.bresp   = bresp_q;
  assign axi_rsp.arready = !rvalid_q;
  assign axi_rsp.rvalid  = rvalid_q;
  assign axi_rsp.rdata   = rdata_q;
  assign axi_rsp.rresp   = rresp_q;

  ////////////////////////////////////////////////////////////////////////////
  // controls to the shift engine and pin mux
  assign ctrl.pins_to_port      = enable;
  assign ctrl.spi_master        = enable && spi_m;
  assign ctrl.spi_slave         = enable && spi_s;
  assign ctrl.ss_used           = enable && (mode == M_SPI_SS);
  assign ctrl.i2c_master        = enable && i2c_m;
  assign ctrl.i2c_slave         = enable && i2c_s;
  assign ctrl.fw_master         = enable && (mode == M_I2C_MFW);
  assign ctrl.ten_bit           = ten;
  assign ctrl.start_stop_irq    = (mode == M_I2C_S7SP) || (mode == M_I2C_S10SP);
  assign ctrl.sample_at_end     = spi_m && stat_sw_q[1];
  assign ctrl.slew_limit        = is_i2c && !stat_sw_q[1];
  assign ctrl.smbus_levels      = is_i2c && stat_sw_q[0];
  assign ctrl.shift_act_to_idle = !is_i2c && stat_sw_q[0];
  assign ctrl.clk_idle_high     = !is_i2c && clock_polarity;
  assign ctrl.scl_hold_low      = enable && i2c_s && !clock_polarity;
  assign ctrl.mode_bad          = bad;
  assign ctrl.sck_tick          = tick_q;
  assign ctrl.tx_load           = txload_q;
  assign ctrl.tx_byte           = txbyte_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  // bus condition and direction flags
  a_stop_clear_dis: assert property (!enable |=> !stop_q && !start_q)
    else $error("start/stop flag survived disable");
  a_start_last: assert property (enable && is_i2c && eng.start_det && !eng.stop_det
    |=> start_q && !stop_q) else $error("start not recorded");
  a_stop_last: assert property (enable && is_i2c && eng.stop_det
    |=> stop_q && !start_q) else $error("stop not recorded");
  a_dna_follow: assert property (is_i2c && eng.byte_done
    |=> dna_q == $past(eng.byte_is_data)) else $error("data flag wrong");
  a_rw_capture: assert property (i2c_s && eng.addr_match
    |=> rw_q == $past(eng.addr_rw)) else $error("rw not captured");
  a_rw_master: assert property (i2c_m |=> rw_q == $past(eng.tx_shifting))
    else $error("transmit flag wrong");
  a_ua_set: assert property (ten && eng.ua_req |=> ua_q)
    else $error("address update missed");
  a_ua_outside: assert property (!ten |=> !ua_q)
    else $error("update flag outside 10-bit mode");
  // sticky errors, buffer and transmit launch
  a_ovf_spi_master: assert property (spi_m && !$past(ovf_q) && !$past(spi_s)
    && !$past(is_i2c) |-> !ovf_q) else $error("overflow in spi master");
  a_ovf_keeps_buf: assert property (ovf_set |=> ovf_q && $stable(rxbuf_q))
    else $error("overflow byte stored");
  a_ovf_sticky: assert property (ovf_q && !wr_ct |=> ovf_q)
    else $error("overflow flag lost");
  a_write_collision_sticky: assert property (write_collision_q && !wr_ct |=> write_collision_q)
    else $error("collision flag lost");
  a_write_collision_drop: assert property (write_collision_set |=> !txload_q)
    else $error("colliding write launched");
  a_txload_pulse: assert property (tx_accept
    |=> txload_q && txbyte_q == $past(wbyte_q)) else $error("buffer write lost");
  a_bf_on_rx: assert property (rx_land |=> bf_q && rxbuf_q == $past(eng.rx_byte))
    else $error("receive not stored");
  a_bf_read: assert property (rd_bf && !rx_land && !i2c_tx |=> !bf_q)
    else $error("buffer full after read");
  a_bf_tx_done: assert property (is_i2c && eng.tx_done && !rx_land && !i2c_tx
    |=> !bf_q) else $error("buffer full after transmit");
  // serial clock rate and bus answer
  a_div4_tick: assert property (tick_q && mode == M_SPI_D4 && enable
    ##1 (mode == M_SPI_D4 && enable) [*4] |-> tick_q)
    else $error("divide by four rate wrong");
  a_t2_half: assert property (enable && t2_rate && eng.t2_match && !t2_half_q
    |=> !tick_q) else $error("timer match ticked early");
  a_tick_halt: assert property (!use_div && !(enable && t2_rate) |=> !tick_q)
    else $error("serial clock ran while halted");
  a_write_answer: assert property (wr_fire |=> bvalid_q)
    else $error("no write response");
  // covers for the main scenarios
  c_i2c_rx_ovf: cover property (is_i2c && ovf_set);
  c_write_collision: cover property (write_collision_set);
  c_stop_seen: cover property ($rose(stop_q));
  c_t2_tick: cover property (t2_rate && tick_q);
  c_ua_rise: cover property ($rose(ua_q));
endmodule

// File: tb/ssp_engine_model.sv
// far-side model: shift engine events as the register bank sees them
// assumes the bench calls its tasks and that everything runs on clk_sys
`timescale 1ns/1ps
module ssp_engine_model
  import ssp_pkg::*;
(
  input  wire logic           clk_sys,
  output ssp_pkg::engine_ev_s eng
);
  logic       shift_q = 1'b0;
  logic [4:0] req_q   = 5'h00;
  initial eng = '0;
  ////////////////////////////////////////////////////////////////////////////
  // levels move only on request, so every collision the bench sees is meant
  task automatic set_lv(input logic sh, input logic [4:0] rq);
    @(posedge clk_sys);
    shift_q = sh;
    req_q = rq;
    eng.tx_shifting <= sh;
    eng.seq_req <= rq;
  endtask
  // one-cycle event; afterwards the byte lines carry the inverse, not stale data
  task automatic pulse(input int k, input logic [7:0] b);
    engine_ev_s e;
    e = '0;
    e.rx_byte = b;
    e.byte_done = k < 2;
    e.byte_is_data = k == 1;
    e.start_det = k == 2;
    e.stop_det = k == 3;
    e.nack_det = k == 4;
    e.addr_match = k == 5;
    e.addr_rw = 1'b1;
    e.t2_match = k == 6;
    e.ua_req = k == 7;
    e.tx_done = k == 8;
    e.tx_shifting = shift_q;
    e.seq_req = req_q;
    @(posedge clk_sys);
    eng <= e;
    e = '0;
    e.rx_byte = ~b;
    e.tx_shifting = shift_q;
    e.seq_req = req_q;
    @(posedge clk_sys);
    eng <= e;
  endtask
endmodule

// File: tb/sync_serial_status_control_tb_top.sv
// bench for the serial port status and control registers
// assumes ssp_regs on clk_sys and the engine model on its event port
`timescale 1ns/1ps
module sync_serial_status_control_tb_top;
  import ssp_pkg::*;
  logic        clk_sys = 1'b0;
  logic        arst_n  = 1'b0;
  axi_req_s    rq      = '0;
  axi_rsp_s    rs;
  engine_ev_s  eng;
  port_ctrl_s  ctrl;
  int          fails   = 0;
  int          checks  = 0;
  logic [31:0] rd_d;
  logic [1:0]  rd_r;
  always #2.5 clk_sys = ~clk_sys;
  ssp_regs u_dut (.clk_sys(clk_sys), .arst_n(arst_n), .axi_req(rq), .axi_rsp(rs),
                  .eng(eng), .ctrl(ctrl));
  ssp_engine_model u_eng (.clk_sys(clk_sys), .eng(eng));
  ////////////////////////////////////////////////////////////////////////////
  // compare and bus tasks; waits end only by the watchdog
  task automatic chk(input logic [31:0] g, input logic [31:0] x, input string w);
    checks++;
    if (g !== x) begin
      fails++;
      $display("[ERR] %0t %s got %h exp %h", $time, w, g, x);
    end
  endtask
  task automatic axw(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    rq.awvalid <= 1'b1;
    rq.awaddr <= a;
    rq.wvalid <= 1'b1;
    rq.wdata <= {24'h00_0000, d};
    rq.wstrb <= 4'hF;
    rq.bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (rs.awready) rq.awvalid <= 1'b0;
      if (rs.wready) rq.wvalid <= 1'b0;
    end while (rs.bvalid !== 1'b1);
    rq.bready <= 1'b0;
    chk(32'(rs.bresp), 32'(RESP_OKAY), "bresp");
  endtask
  task automatic axr(input logic [3:0] a);
    @(posedge clk_sys);
    rq.arvalid <= 1'b1;
    rq.araddr <= a;
    rq.rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (rs.arready) rq.arvalid <= 1'b0;
    end while (rs.rvalid !== 1'b1);
    rq.rready <= 1'b0;
    rd_d = rs.rdata;
    rd_r = rs.rresp;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] x, input string w);
    axr(a);
    chk(rd_d, {24'h00_0000, x}, w);
    chk(32'(rd_r), 32'(RESP_OKAY), "rresp");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset;
    rdc(ADDR_STATUS, STATUS_RESET, "status reset");
    rdc(ADDR_CONTROL, CONTROL_RESET, "control reset");
    axr(4'h2);
    chk(32'(rd_r), 32'(RESP_SLVERR), "unmapped");
    $display("test reset done");
  endtask
  task automatic t_modes;
    logic [6:0] g;
    logic [6:0] x;
    axw(ADDR_RELOAD, 8'h03);
    for (int m = 0; m < 16; m++) begin
      axw(ADDR_CONTROL, {4'h2, 4'(m)});
      g = {ctrl.pins_to_port, ctrl.spi_master, ctrl.spi_slave, ctrl.i2c_slave,
           ctrl.i2c_master, ctrl.fw_master, ctrl.mode_bad};
      x = {1'b1, m inside {0, 1, 2, 3, 10}, m inside {4, 5}, m inside {6, 7, 14, 15},
           m inside {8, 11}, m == 11, m inside {9, 12, 13}};
      chk(32'(g), 32'(x), "mode");
      chk(32'(ctrl.ss_used), 32'(m == 4), "select use");
      chk(32'({ctrl.ten_bit, ctrl.start_stop_irq}),
          32'({m inside {7, 15}, m inside {14, 15}}), "slave kind");
    end
    $display("test modes done");
  endtask
  // serial clock period per divider mode; mode A uses reload 3
  task automatic t_ticks;
    int n;
    logic [3:0] md[4] = '{4'h0, 4'h1, 4'h2, 4'hA};
    int p[4] = '{4, 16, 64, 16};
    foreach (md[i]) begin
      axw(ADDR_CONTROL, {4'h2, md[i]});
      do @(posedge clk_sys); while (ctrl.sck_tick !== 1'b1);
      n = 0;
      do begin
        @(posedge clk_sys);
        n++;
      end while (ctrl.sck_tick !== 1'b1);
      chk(n, p[i], "tick period");
    end
    $display("test ticks done");
  endtask
  // mode 3: one serial period per two timer matches
  task automatic t_timer2;
    int n;
    n = 0;
    axw(ADDR_CONTROL, 8'h23);
    repeat (4) begin
      u_eng.pulse(6, 8'h00);
      @(posedge clk_sys);
      n += int'(ctrl.sck_tick);
    end
    chk(n, 2, "timer rate");
    $display("test timer done");
  endtask
  task automatic t_pins;
    axw(ADDR_CONTROL, 8'h30);
    axw(ADDR_STATUS, 8'hC0);
    chk(32'({ctrl.sample_at_end, ctrl.shift_act_to_idle, ctrl.clk_idle_high, ctrl.slew_limit,
             ctrl.smbus_levels, ctrl.scl_hold_low}), 32'h38, "spi pins");
    axw(ADDR_CONTROL, 8'h26);
    chk(32'({ctrl.sample_at_end, ctrl.shift_act_to_idle, ctrl.clk_idle_high, ctrl.slew_limit,
             ctrl.smbus_levels, ctrl.scl_hold_low}), 32'h03, "i2c pins");
    axw(ADDR_STATUS, 8'h00);
    axw(ADDR_CONTROL, 8'h36);
    chk(32'({ctrl.slew_limit, ctrl.smbus_levels, ctrl.scl_hold_low}), 32'h4, "slew");
    $display("test pins done");
  endtask
  task automatic t_spi;
    axw(ADDR_CONTROL, 8'h24);
    u_eng.pulse(0, 8'hA5);
    rdc(ADDR_STATUS, 8'h01, "slave full");
    u_eng.pulse(0, 8'h3C);
    rdc(ADDR_CONTROL, 8'h64, "slave overflow");
    rdc(ADDR_BUFFER, 8'hA5, "first kept");
    rdc(ADDR_STATUS, 8'h00, "read empties");
    u_eng.set_lv(1'b1, 5'h00);
    axw(ADDR_BUFFER, 8'h55);
    chk(32'(ctrl.tx_load), 32'h0, "collision dropped");
    rdc(ADDR_CONTROL, 8'hE4, "slave collision");
    u_eng.set_lv(1'b0, 5'h00);
    axw(ADDR_CONTROL, 8'h20);
    u_eng.pulse(0, 8'h11);
    u_eng.pulse(0, 8'h22);
    rdc(ADDR_CONTROL, 8'h20, "master no overflow");
    rdc(ADDR_BUFFER, 8'h11, "master buffer");
    $display("test spi done");
  endtask
  task automatic t_i2c;
    axw(ADDR_CONTROL, 8'h36);
    u_eng.pulse(2, 8'h00);
    rdc(ADDR_STATUS, 8'h08, "start");
    u_eng.pulse(5, 8'h00);
    u_eng.pulse(1, 8'h5A);
    rdc(ADDR_STATUS, 8'h2D, "read dir data");
    u_eng.pulse(4, 8'h00);
    rdc(ADDR_STATUS, 8'h29, "nack clears dir");
    u_eng.pulse(5, 8'h00);
    u_eng.pulse(1, 8'h66);
    rdc(ADDR_CONTROL, 8'h76, "i2c overflow");
    u_eng.pulse(3, 8'h00);
    rdc(ADDR_STATUS, 8'h31, "stop");
    axw(ADDR_CONTROL, 8'h06);
    chk(32'(ctrl.pins_to_port), 32'h0, "pins released");
    rdc(ADDR_STATUS, 8'h21, "disable clears");
    rdc(ADDR_BUFFER, 8'h5A, "i2c buffer");
    axw(ADDR_CONTROL, 8'h37);
    u_eng.pulse(7, 8'h00);
    rdc(ADDR_STATUS, 8'h22, "address update");
    axw(ADDR_RELOAD, 8'h03);
    rdc(ADDR_STATUS, 8'h20, "update done");
    axw(ADDR_CONTROL, 8'h28);
    u_eng.set_lv(1'b1, 5'h00);
    rdc(ADDR_STATUS, 8'h24, "master busy");
    axw(ADDR_BUFFER, 8'h99);
    rdc(ADDR_CONTROL, 8'hA8, "collision");
    u_eng.set_lv(1'b0, 5'h00);
    axw(ADDR_CONTROL, 8'h28);
    axw(ADDR_BUFFER, 8'h77);
    chk(32'({ctrl.tx_load, ctrl.tx_byte}), 32'h177, "tx launch");
    rdc(ADDR_CONTROL, 8'h28, "no collision");
    rdc(ADDR_STATUS, 8'h21, "tx full");
    u_eng.pulse(8, 8'h00);
    rdc(ADDR_STATUS, 8'h20, "tx done");
    $display("test i2c done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // verdict and run control; the watchdog allows some forty times the expected run
  task automatic test_done;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    test_done;
  end
  initial begin
    repeat (3) @(posedge clk_sys);
    arst_n <= 1'b1;
    t_reset;
    t_modes;
    t_ticks;
    t_timer2;
    t_pins;
    t_spi;
    t_i2c;
    test_done;
  end
endmodule
